// [design/usf_status_flags.sv]
// Receive and transmit status flags, interrupt and DMA request logic
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Operation
// - Parity fault sets bit 0, read clears
// - Missing stop bit sets bit 1, read clears
// - Unread buffer overwritten sets bit 2, read clears
// - Summary bit 3 follows any fault flag
// - Writes to summary bit are ignored
// - Break: low ten bit times after bad stop
// - Read clears break only with line high
// - Held break clears when line returns high
// - Ninth bit of last frame in bit 5
// - Transmitting flag bit 6, cleared after last frame
// - Line status byte wide, read only, resets zero
// - TX empty set on shifter load, cleared on write
// - RX full set on frame, cleared on read
// - Enable bit 5 gates TX empty interrupt
// - Enable bit 6 gates RX full interrupt
// - Enable bit 7 gates fault interrupt
// - Control byte resets 01, bits 4-2 reserved
// - DMA requests follow empty and full flags
module usf_status_flags
	import usf_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Register port
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic write_i,
	input wire logic read_i,
	output logic [7:0] rdata_o,
	// Receive side
	input wire logic rx_line_i,
	input wire logic bit_tick_i,
	input wire usf_rx_frame_t rx_frame_i,
	input wire logic rx_buffer_read_i,
	input wire logic nine_bit_mode_i,
	// Transmit side
	input wire logic tx_buffer_write_i,
	input wire logic tx_load_i,
	input wire logic tx_last_bit_end_i,
	// DMA enables from the mode register
	input wire logic tx_dma_enable_i,
	input wire logic rx_dma_enable_i,
	// Requests
	output logic irq_o,
	output logic tx_dma_req_o,
	output logic rx_dma_req_o
);

	////////////////////////////////////////////////////////////////////////
	// Decode

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] target);
		hit = (a == target);
	endfunction

	usf_state_t s_reg;
	usf_state_t s_next;

	logic lstat_rd;
	logic ev_rd;
	logic line_high;
	logic [EV_W-1:0] ev_new;
	logic [7:0] ictrl_view;

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		s_next = s_reg;
		ev_new = '0;
		ictrl_view = '0;
		lstat_rd = read_i && hit(addr_i, ADDR_LSTAT);
		ev_rd = read_i && hit(addr_i, ADDR_EVSTAT);
		// Only the second stage is read
		s_next.line_sync1 = rx_line_i;
		s_next.line_sync2 = s_reg.line_sync1;
		line_high = s_reg.line_sync2;

		// Read side clears go first so that a same-cycle set wins
		if (lstat_rd) begin
			s_next.lstat.parity_fault_flag = 1'b0;
			s_next.lstat.framing_fault_flag = 1'b0;
			s_next.lstat.overrun_fault_flag = 1'b0;
			if (line_high) begin
				s_next.lstat.line_break_flag = 1'b0;
			end else if (s_reg.lstat.line_break_flag) begin
				s_next.brk_hold = 1'b1;
			end
		end
		if (s_reg.brk_hold && line_high) begin
			s_next.lstat.line_break_flag = 1'b0;
			s_next.brk_hold = 1'b0;
		end
		if (rx_buffer_read_i) begin
			s_next.rx_buffer_full = 1'b0;
		end
		if (tx_buffer_write_i) begin
			s_next.tx_buffer_empty = 1'b0;
		end

		// Break timing restarts on every bad stop bit
		if (rx_frame_i.done && rx_frame_i.stop_bad) begin
			s_next.brk_armed = 1'b1;
			s_next.brk_cnt = '0;
		end else if (s_reg.brk_armed) begin
			if (line_high) begin
				s_next.brk_armed = 1'b0;
			end else if (bit_tick_i) begin
				if (s_reg.brk_cnt == BREAK_BIT_TIMES - 4'h1) begin
					s_next.lstat.line_break_flag = 1'b1;
					s_next.brk_armed = 1'b0;
					ev_new[EV_BREAK_BIT] = 1'b1;
				end else begin
					s_next.brk_cnt = s_reg.brk_cnt + 4'h1;
				end
			end
		end

		// Frame arrival into the receive buffer
		if (rx_frame_i.done) begin
			if (rx_frame_i.parity_bad) begin
				s_next.lstat.parity_fault_flag = 1'b1;
			end
			if (rx_frame_i.stop_bad) begin
				s_next.lstat.framing_fault_flag = 1'b1;
			end
			// A buffer read in the same cycle took the old character
			if (s_reg.rx_buffer_full && !rx_buffer_read_i) begin
				s_next.lstat.overrun_fault_flag = 1'b1;
			end
			if (nine_bit_mode_i) begin
				s_next.lstat.received_ninth_bit = rx_frame_i.ninth;
			end
			s_next.rx_buffer_full = 1'b1;
			ev_new[EV_RXERR_BIT] = rx_frame_i.parity_bad
				| rx_frame_i.stop_bad
				| (s_reg.rx_buffer_full & ~rx_buffer_read_i);
		end

		// Transmit flags
		if (tx_last_bit_end_i && s_reg.tx_buffer_empty) begin
			s_next.lstat.transmit_in_progress = 1'b0;
			ev_new[EV_TXDONE_BIT] = 1'b1;
		end
		if (tx_load_i) begin
			s_next.tx_buffer_empty = 1'b1;
			s_next.lstat.transmit_in_progress = 1'b1;
		end

		// Summary bit is derived, never written
		s_next.lstat.summary_fault_flag =
			s_next.lstat.parity_fault_flag
			| s_next.lstat.framing_fault_flag
			| s_next.lstat.overrun_fault_flag;
		s_next.lstat.reserved = 1'b0;

		// Software writes; the line status register takes none
		if (write_i && hit(addr_i, ADDR_ICTRL)) begin
			s_next.tx_interrupt_enable = wdata_i[ICTRL_ETI_BIT];
			s_next.rx_interrupt_enable = wdata_i[ICTRL_ERI_BIT];
			s_next.rx_fault_interrupt_enable = wdata_i[ICTRL_EEI_BIT];
		end
		if (write_i && hit(addr_i, ADDR_EVMASK)) begin
			s_next.ev_mask = wdata_i[EV_W-1:0];
		end

		// Event status, read to clear, new events win
		if (ev_rd) begin
			s_next.ev_stat = '0;
		end
		s_next.ev_stat = s_next.ev_stat | ev_new;

		// Read data stands only in the cycle after the strobe
		ictrl_view[ICTRL_TBE_BIT] = s_reg.tx_buffer_empty;
		ictrl_view[ICTRL_RBF_BIT] = s_reg.rx_buffer_full;
		ictrl_view[ICTRL_ETI_BIT] = s_reg.tx_interrupt_enable;
		ictrl_view[ICTRL_ERI_BIT] = s_reg.rx_interrupt_enable;
		ictrl_view[ICTRL_EEI_BIT] = s_reg.rx_fault_interrupt_enable;
		s_next.rdata = '0;
		if (read_i) begin
			if (hit(addr_i, ADDR_ICTRL)) begin
				s_next.rdata = ictrl_view;
			end else if (lstat_rd) begin
				s_next.rdata = s_reg.lstat;
			end else if (ev_rd) begin
				s_next.rdata = {{(8-EV_W){1'b0}}, s_reg.ev_stat};
			end else if (hit(addr_i, ADDR_EVMASK)) begin
				s_next.rdata = {{(8-EV_W){1'b0}}, s_reg.ev_mask};
			end
		end

		// Requests follow the next flag values to stay aligned
		s_next.irq = (s_next.tx_interrupt_enable
			& s_next.tx_buffer_empty)
			| (s_next.rx_interrupt_enable
			& s_next.rx_buffer_full)
			| (s_next.rx_fault_interrupt_enable
			& s_next.lstat.summary_fault_flag)
			| (|(s_next.ev_stat & s_next.ev_mask));
		s_next.tx_dma_req = tx_dma_enable_i
			& s_next.tx_buffer_empty;
		s_next.rx_dma_req = rx_dma_enable_i
			& s_next.rx_buffer_full;
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_reg <= STATE_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rdata_o = s_reg.rdata;
	assign irq_o = s_reg.irq;
	assign tx_dma_req_o = s_reg.tx_dma_req;
	assign rx_dma_req_o = s_reg.rx_dma_req;

endmodule // usf_status_flags

// [design/usf_pkg.sv]
// Shared constants and types of the serial status and interrupt flag block
package usf_pkg;

	localparam int ADDR_W = 24;

	// Register addresses
	localparam logic [23:0] ADDR_ICTRL = 24'h00fd24;
	localparam logic [23:0] ADDR_LSTAT = 24'h00fd26;
	localparam logic [23:0] ADDR_EVSTAT = 24'h00fd30;
	localparam logic [23:0] ADDR_EVMASK = 24'h00fd32;

	// Reset values
	localparam logic [7:0] ICTRL_RESET = 8'h01;
	localparam logic [7:0] LSTAT_RESET = 8'h00;
	localparam logic [7:0] EV_RESET = 8'h00;

	// Interrupt control field positions
	localparam int ICTRL_TBE_BIT = 0;
	localparam int ICTRL_RBF_BIT = 1;
	localparam int ICTRL_ETI_BIT = 5;
	localparam int ICTRL_ERI_BIT = 6;
	localparam int ICTRL_EEI_BIT = 7;

	// Event status and mask field positions
	localparam int EV_W = 3;
	localparam int EV_BREAK_BIT = 0;
	localparam int EV_RXERR_BIT = 1;
	localparam int EV_TXDONE_BIT = 2;

	// Bit times of low line that make a break
	localparam logic [3:0] BREAK_BIT_TIMES = 4'ha;

	// Line status layout, bit 7 down to bit 0
	typedef struct packed {
		logic reserved;
		logic transmit_in_progress;
		logic received_ninth_bit;
		logic line_break_flag;
		logic summary_fault_flag;
		logic overrun_fault_flag;
		logic framing_fault_flag;
		logic parity_fault_flag;
	} usf_line_status_t;

	// Frame handed from the receive shifter to the receive buffer
	typedef struct packed {
		logic done;
		logic parity_bad;
		logic stop_bad;
		logic ninth;
	} usf_rx_frame_t;

	typedef struct packed {
		usf_line_status_t lstat;
		logic tx_buffer_empty;
		logic rx_buffer_full;
		logic tx_interrupt_enable;
		logic rx_interrupt_enable;
		logic rx_fault_interrupt_enable;
		logic [EV_W-1:0] ev_stat;
		logic [EV_W-1:0] ev_mask;
		logic brk_armed;
		logic brk_hold;
		logic [3:0] brk_cnt;
		logic line_sync1;
		logic line_sync2;
		logic [7:0] rdata;
		logic irq;
		logic tx_dma_req;
		logic rx_dma_req;
	} usf_state_t;

	localparam usf_state_t STATE_RESET = '{
		lstat: LSTAT_RESET,
		tx_buffer_empty: ICTRL_RESET[ICTRL_TBE_BIT],
		line_sync1: 1'b1,
		line_sync2: 1'b1,
		default: '0
	};

endpackage

// [verification/usf_status_flags_sva.sv]
// Checker of the status flag block ports
`timescale 1ns/1ps
module usf_flags_chk
	import usf_pkg::*;
(
	// Clock and register port
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic read_i,
	input wire logic [7:0] rdata_o,
	// Events and requests
	input wire usf_rx_frame_t rx_frame_i,
	input wire logic rx_buffer_read_i,
	input wire logic tx_buffer_write_i,
	input wire logic tx_load_i,
	input wire logic tx_dma_req_o,
	input wire logic rx_dma_req_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	logic st_rd;
	assign st_rd = read_i && addr_i == ADDR_LSTAT;
	idle_read_a: assert property (!read_i
		|=> rdata_o == 8'h00) else $error("read data not zero");
	stat_rsv_a: assert property (st_rd
		|=> !rdata_o[7]) else $error("reserved bit set");
	err_sum_a: assert property (st_rd
		|=> rdata_o[3] == |rdata_o[2:0]) else $error("bad summary");
	ctrl_rsv_a: assert property (read_i && addr_i == ADDR_ICTRL
		|=> rdata_o[4:2] == 3'h0) else $error("reserved bits set");
	parity_set_a: assert property (rx_frame_i.done &&
		rx_frame_i.parity_bad ##1 st_rd |=> rdata_o[0])
		else $error("no parity flag");
	stop_set_a: assert property (rx_frame_i.done &&
		rx_frame_i.stop_bad ##1 st_rd |=> rdata_o[1])
		else $error("no framing flag");
	tx_clr_a: assert property (tx_buffer_write_i && !tx_load_i
		|=> !tx_dma_req_o) else $error("tx request stays");
	rx_clr_a: assert property (rx_buffer_read_i && !rx_frame_i.done
		|=> !rx_dma_req_o) else $error("rx request stays");
endmodule // usf_flags_chk

bind usf_status_flags usf_flags_chk i_chk (.clk_i(clk_i),
	.reset_i(reset_i), .addr_i(addr_i), .read_i(read_i),
	.rdata_o(rdata_o), .rx_frame_i(rx_frame_i),
	.rx_buffer_read_i(rx_buffer_read_i),
	.tx_buffer_write_i(tx_buffer_write_i), .tx_load_i(tx_load_i),
	.tx_dma_req_o(tx_dma_req_o), .rx_dma_req_o(rx_dma_req_o));

// [verification/usf_remote_device.sv]
// Model of the remote sender on the receive line
`timescale 1ns/1ps
module usf_remote_device
	import usf_pkg::*;
(
	// Clock and command
	input wire logic clk_i,
	input wire logic go_i,
	input wire usf_rx_frame_t kind_i,
	// Line, bit timing, frame
	output logic rx_line_o,
	output logic bit_tick_o,
	output usf_rx_frame_t frame_o
);
	logic [1:0] div_reg = 2'h0;
	logic [4:0] low_reg = 5'h00;
	// Frame report trails the line: a bad stop bit is already low on the pin
	usf_rx_frame_t d1_reg = '0;
	usf_rx_frame_t d2_reg = '0;
	assign bit_tick_o = div_reg == 2'h3;
	// Idles high; a bad stop bit starts a long break
	assign rx_line_o = low_reg == 5'h00;
	always_ff @(posedge clk_i) begin
		div_reg <= div_reg + 2'h1;
		d1_reg <= go_i ? kind_i : '0;
		d2_reg <= d1_reg;
		frame_o <= d2_reg;
		if (go_i && kind_i.stop_bad)
			low_reg <= 5'h14;
		else if (bit_tick_o && low_reg != 5'h00)
			low_reg <= low_reg - 5'h01;
	end
endmodule // usf_remote_device

// [verification/test_usart_status_interrupt_flags.sv]
// Register-level test of the serial status flag block
`timescale 1ns/1ps
module test_usart_status_interrupt_flags
	import usf_pkg::*;
;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [ADDR_W-1:0] addr_i = '0;
	logic [7:0] wdata_i = 8'h00;
	logic write_i = 1'b0;
	logic read_i = 1'b0;
	logic [3:0] ev = 4'h0;
	logic go = 1'b0;
	logic dma_en = 1'b0;
	usf_rx_frame_t kind = '0;
	usf_rx_frame_t frame;
	logic [7:0] rdata_o;
	logic irq_o, rx_line, tick, tx_req, rx_req;
	int errors = 0;
	int checks = 0;
	int n;
	initial forever #10 clk_i = ~clk_i;
	usf_remote_device i_far (.clk_i(clk_i), .go_i(go), .kind_i(kind),
		.rx_line_o(rx_line), .bit_tick_o(tick), .frame_o(frame));
	usf_status_flags i_dut (.clk_i(clk_i), .reset_i(reset_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i),
		.read_i(read_i), .rdata_o(rdata_o), .rx_line_i(rx_line),
		.bit_tick_i(tick), .rx_frame_i(frame), .rx_buffer_read_i(ev[3]),
		.nine_bit_mode_i(1'b1), .tx_buffer_write_i(ev[2]),
		.tx_load_i(ev[1]), .tx_last_bit_end_i(ev[0]),
		.tx_dma_enable_i(dma_en), .rx_dma_enable_i(dma_en),
		.irq_o(irq_o), .tx_dma_req_o(tx_req), .rx_dma_req_o(rx_req));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk_i);
		write_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		write_i <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		read_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		read_i <= 1'b0;
		#1 chk(rdata_o, exp);
	endtask
	task automatic pulse(input logic [3:0] v);
		@(posedge clk_i);
		ev <= v;
		@(posedge clk_i);
		ev <= 4'h0;
	endtask
	task automatic send(input usf_rx_frame_t k);
		@(posedge clk_i);
		go <= 1'b1;
		kind <= k;
		@(posedge clk_i);
		go <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask
	task automatic irq_is(input logic exp);
		@(posedge clk_i);
		#1 chk({7'h00, irq_o}, {7'h00, exp});
	endtask
	task automatic wrap_up;
		if (errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		reset_i <= 1'b0;
		rd(ADDR_ICTRL, 8'h01);
		rd(ADDR_LSTAT, 8'h00);
		wr(ADDR_ICTRL, 8'hff);
		rd(ADDR_ICTRL, 8'he1);
		irq_is(1'b1);
		wr(ADDR_LSTAT, 8'hff);
		rd(ADDR_LSTAT, 8'h00);
		rd(24'h00fd28, 8'h00);
		wr(ADDR_ICTRL, 8'h20);
		pulse(4'h4);
		irq_is(1'b0);
		pulse(4'h2);
		irq_is(1'b1);
		rd(ADDR_LSTAT, 8'h40);
		pulse(4'h1);
		rd(ADDR_LSTAT, 8'h00);
		dma_en <= 1'b1;
		wr(ADDR_ICTRL, 8'h80);
		chk({6'h00, tx_req, rx_req}, 8'h02);
		send(4'b1101);
		rd(ADDR_LSTAT, 8'h29);
		send(4'b1100);
		irq_is(1'b1);
		rd(ADDR_LSTAT, 8'h0d);
		irq_is(1'b0);
		wr(ADDR_ICTRL, 8'h40);
		irq_is(1'b1);
		pulse(4'h8);
		rd(ADDR_ICTRL, 8'h41);
		send(4'b1010);
		rd(ADDR_LSTAT, 8'h0a);
		repeat (60) @(posedge clk_i);
		rd(ADDR_LSTAT, 8'h10);
		rd(ADDR_LSTAT, 8'h10);
		for (n = 0; n < 200 && !rx_line; n++)
			@(posedge clk_i);
		if (!rx_line) begin
			errors++;
			wrap_up;
		end
		repeat (4) @(posedge clk_i);
		rd(ADDR_LSTAT, 8'h00);
		wrap_up;
	end
endmodule // test_usart_status_interrupt_flags
